//--- hdl/scr_pkg.sv
// Purpose: Constants and types of the system configuration register block
// Assumes: 10 MHz system clock, 16-bit serial frames, MSB first
// Notes:   Shared by the design and the bench

package scr_pkg;

    // ****************************************************************
    // Frame layout
    // ****************************************************************
    localparam logic [4:0] FRAME_BITS  = 5'h10;
    localparam logic [4:0] CNT_MAX     = 5'h1f;
    localparam logic [4:0] RRS_CNT     = 5'h02;
    localparam logic [4:0] SEL_CNT     = 5'h03;
    localparam logic [1:0] SEL_CODE    = 2'b10;
    localparam logic [11:0] CFG_RESET  = 12'h000;

    // ****************************************************************
    // Aux supply modes
    // ****************************************************************
    localparam logic [1:0] AUX_OFF       = 2'b00;
    localparam logic [1:0] AUX_ON        = 2'b01;
    localparam logic [1:0] AUX_CYC_SHORT = 2'b10;
    localparam logic [1:0] AUX_CYC_LONG  = 2'b11;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SYS_CLK_KHZ  = 10000;
    localparam int RST_SHORT_US = 1000;
    localparam int RST_LONG_US  = 20000;

    typedef struct packed {
        logic [1:0] rsvd_hi;
        logic       gnd_thr;
        logic       rst_len;
        logic [1:0] aux_mode;
        logic       rsvd_lo;
        logic       cur_resp;
        logic       wake_en;
        logic       wake_samp;
        logic       inh_en;
        logic       inh_lvl;
    } scr_cfg_s;

    typedef struct packed {
        logic [1:0] code;
        logic       readback_source_select;
        logic       ro;
        scr_cfg_s   cfg;
    } scr_frame_s;

    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_EXT  = 2'b01,
        RS_HOLD = 2'b11
    } scr_rst_e;

endpackage : scr_pkg

//--- hdl/scr_top.sv
// Purpose: System configuration register with serial access and outputs
// Assumes: Serial clock idles low, data sampled on rising edge
// Notes:   Chip select low to first clock at least 400 ns

`timescale 1ns/100ps
`default_nettype none

module scr_top
    import scr_pkg::*;
#(
    parameter int CNT_W         = 24,
    parameter int RST_SHORT_CYC = RST_SHORT_US * (SYS_CLK_KHZ / 1000),
    parameter int RST_LONG_CYC  = RST_LONG_US * (SYS_CLK_KHZ / 1000)
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        spi_sck,
    input  wire logic        spi_csn,
    input  wire logic        spi_mosi,
    output logic             spi_miso_o,
    output logic             spi_miso_oe,
    input  wire logic [15:0] gp_feedback0,
    input  wire logic        restart_entry,
    input  wire logic        failsafe_entry,
    input  wire logic        reset_ext_n,
    output logic             reset_out_n,
    input  wire logic        wake_pin,
    input  wire logic        wake_sample_tick,
    output logic             wake_event,
    output logic             wake_pin_status_a,
    output logic             wake_pin_status_b,
    input  wire logic        standby_mode,
    input  wire logic        wdog_off_standby,
    input  wire logic        main_current_rise,
    input  wire logic        main_current_irq_en,
    output logic             main_current_reset,
    output logic             wdog_reenable,
    output logic             main_current_irq,
    output logic             spi_count_fail,
    output logic             ground_offset_threshold_sel,
    output logic [1:0]       aux_supply_mode,
    output logic             inhibit_limp_home_pin_o,
    output logic             inhibit_limp_home_pin_oe
);

    localparam logic [CNT_W-1:0] LEN_SHORT = CNT_W'(RST_SHORT_CYC - 1);
    localparam logic [CNT_W-1:0] LEN_LONG  = CNT_W'(RST_LONG_CYC - 1);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) rst_sync_r <= 2'b00;
        else       rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // ****************************************************************
    // Link side shifter
    // ****************************************************************
    logic        in_frame_r;
    logic [4:0]  bit_cnt_r;
    logic [4:0]  bit_cnt_nxt;
    logic [15:0] shift_r;
    logic        frame_tog_r;
    logic        rrs_r;
    logic        miso_r;
    logic [15:0] rb_r;
    logic [15:0] gp_r;
    logic [3:0]  out_idx;
    logic        out_bit;

    always_ff @(posedge spi_sck or posedge spi_csn) begin
        if (spi_csn) in_frame_r <= 1'b0;
        else         in_frame_r <= 1'b1;
    end

    assign bit_cnt_nxt = !in_frame_r ? 5'h01 :
                         (bit_cnt_r == CNT_MAX) ? bit_cnt_r :
                         bit_cnt_r + 5'h01;

    always_ff @(posedge spi_sck or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_r   <= 5'h00;
            shift_r     <= 16'h0000;
            frame_tog_r <= 1'b0;
            rrs_r       <= 1'b0;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            shift_r   <= {shift_r[14:0], spi_mosi};
            if (!in_frame_r)
                frame_tog_r <= ~frame_tog_r;
            if (in_frame_r && bit_cnt_r == RRS_CNT)
                rrs_r <= spi_mosi;
        end
    end

    assign out_idx = 4'hf - bit_cnt_r[3:0];
    assign out_bit = (bit_cnt_r >= FRAME_BITS) ? 1'b0 :
                     (bit_cnt_r >= SEL_CNT && rrs_r) ? gp_r[out_idx] :
                     rb_r[out_idx];

    always_ff @(negedge spi_sck or negedge rstn) begin
        if (!rstn) miso_r <= 1'b0;
        else       miso_r <= out_bit;
    end

    assign spi_miso_o  = in_frame_r ? miso_r : rb_r[15];
    assign spi_miso_oe = ~spi_csn;

    // ****************************************************************
    // Frame end detection
    // ****************************************************************
    logic       csn_s1_r;
    logic       csn_s2_r;
    logic       csn_s3_r;
    logic       tog_s1_r;
    logic       tog_s2_r;
    logic       tog_seen_r;
    logic       frame_end;
    logic       frame_new;
    logic       count_ok;
    logic       addr_hit;
    logic       do_write;
    logic       count_fail;
    logic       mode_entry;
    scr_frame_s cap;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            csn_s1_r <= 1'b1;
            csn_s2_r <= 1'b1;
            csn_s3_r <= 1'b1;
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
        end else begin
            csn_s1_r <= spi_csn;
            csn_s2_r <= csn_s1_r;
            csn_s3_r <= csn_s2_r;
            tog_s1_r <= frame_tog_r;
            tog_s2_r <= tog_s1_r;
        end
    end

    assign cap        = shift_r;
    assign frame_end  = csn_s2_r & ~csn_s3_r;
    assign frame_new  = tog_s2_r != tog_seen_r;
    assign count_ok   = frame_new && bit_cnt_r == FRAME_BITS;
    assign addr_hit   = count_ok && cap.code == SEL_CODE;
    assign do_write   = frame_end && addr_hit && !cap.ro;
    assign count_fail = frame_end && !count_ok;
    assign mode_entry = restart_entry | failsafe_entry;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)         tog_seen_r <= 1'b0;
        else if (frame_end) tog_seen_r <= tog_s2_r;
    end

    // ****************************************************************
    // Configuration register
    // ****************************************************************
    scr_cfg_s cfg_r;
    scr_cfg_s cfg_nxt;
    logic     fail_r;

    always_comb begin
        cfg_nxt = cfg_r;
        if (do_write)
            cfg_nxt = cap.cfg;
        if (mode_entry)
            cfg_nxt.rst_len = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r  <= CFG_RESET;
            fail_r <= 1'b0;
            rb_r   <= 16'h0000;
            gp_r   <= 16'h0000;
        end else begin
            cfg_r  <= cfg_nxt;
            fail_r <= count_fail;
            if (csn_s2_r) begin
                rb_r <= {SEL_CODE, 2'b00, cfg_r};
                gp_r <= gp_feedback0;
            end
        end
    end

    assign spi_count_fail              = fail_r;
    assign ground_offset_threshold_sel = cfg_r.gnd_thr;
    assign aux_supply_mode             = cfg_r.aux_mode;
    assign inhibit_limp_home_pin_oe    = cfg_r.inh_en;
    assign inhibit_limp_home_pin_o     = cfg_r.inh_lvl;

    // ****************************************************************
    // Wake input
    // ****************************************************************
    logic wake_s1_r;
    logic wake_s2_r;
    logic wake_lvl_r;
    logic wake_prv_r;
    logic wake_ev_r;
    logic wake_upd;
    logic wake_fall;

    assign wake_upd  = cfg_r.wake_en &
                       (cfg_r.wake_samp ? wake_sample_tick : 1'b1);
    assign wake_fall = wake_upd & wake_lvl_r & ~wake_s2_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_s1_r  <= 1'b1;
            wake_s2_r  <= 1'b1;
            wake_lvl_r <= 1'b1;
            wake_prv_r <= 1'b1;
            wake_ev_r  <= 1'b0;
        end else begin
            wake_s1_r <= wake_pin;
            wake_s2_r <= wake_s1_r;
            wake_ev_r <= wake_fall;
            if (wake_upd) begin
                wake_lvl_r <= wake_s2_r;
                wake_prv_r <= wake_lvl_r;
            end
        end
    end

    assign wake_event        = wake_ev_r;
    assign wake_pin_status_a = wake_lvl_r;
    assign wake_pin_status_b = wake_prv_r;

    // ****************************************************************
    // Main supply current response
    // ****************************************************************
    logic cur_hit;
    logic cur_reset_r;
    logic cur_wdog_r;
    logic cur_irq_r;

    assign cur_hit = main_current_rise & standby_mode;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_reset_r <= 1'b0;
            cur_wdog_r  <= 1'b0;
            cur_irq_r   <= 1'b0;
        end else begin
            cur_reset_r <= cur_hit & wdog_off_standby & cfg_r.cur_resp;
            cur_wdog_r  <= cur_hit & ~cfg_r.cur_resp;
            cur_irq_r   <= cur_hit & ~cfg_r.cur_resp & main_current_irq_en;
        end
    end

    assign main_current_reset = cur_reset_r;
    assign wdog_reenable      = cur_wdog_r;
    assign main_current_irq   = cur_irq_r;

    // ****************************************************************
    // Reset stretching
    // ****************************************************************
    logic             rext_s1_r;
    logic             rext_s2_r;
    scr_rst_e         rs_st_r;
    scr_rst_e         rs_st_nxt;
    logic [CNT_W-1:0] rs_cnt_r;
    logic [CNT_W-1:0] rs_len;
    logic             rs_done;
    logic             rst_out_r;

    assign rs_len  = cfg_r.rst_len ? LEN_LONG : LEN_SHORT;
    assign rs_done = rs_cnt_r >= rs_len;

    always_comb begin
        rs_st_nxt = rs_st_r;
        unique case (rs_st_r)
            RS_IDLE: if (!rext_s2_r) rs_st_nxt = RS_EXT;
            RS_EXT:  if (rext_s2_r) rs_st_nxt = rs_done ? RS_IDLE : RS_HOLD;
            RS_HOLD: if (!rext_s2_r) rs_st_nxt = RS_EXT;
                     else if (rs_done) rs_st_nxt = RS_IDLE;
            default: rs_st_nxt = RS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rext_s1_r <= 1'b1;
            rext_s2_r <= 1'b1;
            rs_st_r   <= RS_IDLE;
            rs_cnt_r  <= '0;
            rst_out_r <= 1'b1;
        end else begin
            rext_s1_r <= reset_ext_n;
            rext_s2_r <= rext_s1_r;
            rs_st_r   <= rs_st_nxt;
            rst_out_r <= rs_st_nxt == RS_IDLE;
            if (rs_st_r == RS_IDLE)
                rs_cnt_r <= '0;
            else if (!rs_done)
                rs_cnt_r <= rs_cnt_r + 1'b1;
        end
    end

    assign reset_out_n = rst_out_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_store;
        frame_end && addr_hit && !cap.ro && !mode_entry;
    endsequence

    sequence s_wake_fall;
        wake_upd && wake_lvl_r && !wake_s2_r;
    endsequence

    a_write_applies: assert property (
        s_store |=> cfg_r == $past(cap.cfg))
        else $error("stored value differs from frame");

    a_read_only: assert property (
        frame_end && cap.ro && !mode_entry |=> $stable(cfg_r))
        else $error("read-only frame changed config");

    a_bad_count: assert property (
        frame_end && !count_ok && !mode_entry
            |=> spi_count_fail && $stable(cfg_r))
        else $error("bad clock count not discarded");

    a_no_midframe: assert property (
        !csn_s2_r && !mode_entry |=> $stable(cfg_r))
        else $error("config changed during frame");

    a_len_forced: assert property (
        mode_entry |=> cfg_r.rst_len)
        else $error("reset length not forced long");

    a_inh_follow: assert property (
        s_store ##1 1'b1 |-> inhibit_limp_home_pin_oe == $past(cap.cfg.inh_en)
            && inhibit_limp_home_pin_o == $past(cap.cfg.inh_lvl))
        else $error("inhibit pin not following write");

    a_wake_frozen: assert property (
        !cfg_r.wake_en |=> $stable({wake_lvl_r, wake_prv_r}) && !wake_event)
        else $error("wake status moved while disabled");

    a_wake_edge: assert property (
        s_wake_fall |=> wake_event ##1 !wake_event)
        else $error("wake falling edge not reported");

    a_cur_reset: assert property (
        cur_hit && wdog_off_standby && cfg_r.cur_resp
            |=> main_current_reset && !wdog_reenable)
        else $error("current rise did not reset");

    a_cur_wdog: assert property (
        cur_hit && !cfg_r.cur_resp
            |=> wdog_reenable && !main_current_reset
            && main_current_irq == $past(main_current_irq_en))
        else $error("current rise did not re-enable watchdog");

    a_stretch_len: assert property (
        $rose(reset_out_n) |-> $past(rs_done) && $past(rext_s2_r))
        else $error("reset released before stretch time");

    a_stretch_start: assert property (
        rs_st_r == RS_IDLE && !rext_s2_r |=> !reset_out_n)
        else $error("external reset not passed on");

endmodule : scr_top

`default_nettype wire

//--- testbench/scr_host.sv
// Purpose: Serial host model sending frames to the register block
// Assumes: Link clock period 125 ns, idles low, data read on rise
// Notes:   Link clock stands still between frames

`timescale 1ns/100ps
`default_nettype none

module scr_host (
    output logic      sck,
    output logic      csn,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sck  = 1'b0;
        csn  = 1'b1;
        mosi = 1'b0;
    end

    // ****************************************************************
    // Frame of n link clocks, MSB first
    // ****************************************************************
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [15:0] r);
        r = 16'h0000;
        csn = 1'b0;
        #400;
        for (int k = 0; k < n; k++) begin
            mosi = w[15 - (k % 16)];
            #62.5 sck = 1'b1;
            r = {r[14:0], miso};
            #62.5 sck = 1'b0;
        end
        #62.5 csn = 1'b1;
        mosi = ~mosi;
        #400;
    endtask : xfer
endmodule : scr_host

`default_nettype wire

//--- testbench/system_config_register_tb.sv
// Purpose: Self-checking bench of the configuration register block
// Assumes: Short and long reset stretch shortened to 8 and 20 cycles
// Notes:   Model holds the stored settings and pulse counts

`timescale 1ns/100ps
`default_nettype none

module system_config_register_tb import scr_pkg::*;;
    localparam int LSHORT = 8;
    localparam int LLONG  = 20;
    logic        sys_clk, rstn, restart_entry, failsafe_entry;
    logic        reset_ext_n, reset_out_n, wake_pin, wake_tick;
    logic        wake_event, st_a, st_b, standby, wd_off, cur_rise;
    logic        irq_en, cur_rst, reen, cur_irq, cnt_fail, gnd;
    logic        inh_o, inh_oe, miso_o, miso_oe, sck, csn, mosi;
    logic [1:0]  aux;
    logic [15:0] gp, rd;
    logic [11:0] m_cfg;
    int          n_fail, compares, seed, cf_exp, lo_cnt, lo_max;
    int          n_ev [5];
    wire logic   miso = miso_oe ? miso_o : 1'bz;

    scr_top #(.RST_SHORT_CYC(LSHORT), .RST_LONG_CYC(LLONG)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .spi_sck(sck), .spi_csn(csn),
        .spi_mosi(mosi), .spi_miso_o(miso_o), .spi_miso_oe(miso_oe),
        .gp_feedback0(gp), .restart_entry(restart_entry),
        .failsafe_entry(failsafe_entry), .reset_ext_n(reset_ext_n),
        .reset_out_n(reset_out_n), .wake_pin(wake_pin),
        .wake_sample_tick(wake_tick), .wake_event(wake_event),
        .wake_pin_status_a(st_a), .wake_pin_status_b(st_b),
        .standby_mode(standby), .wdog_off_standby(wd_off),
        .main_current_rise(cur_rise), .main_current_irq_en(irq_en),
        .main_current_reset(cur_rst), .wdog_reenable(reen),
        .main_current_irq(cur_irq), .spi_count_fail(cnt_fail),
        .ground_offset_threshold_sel(gnd), .aux_supply_mode(aux),
        .inhibit_limp_home_pin_o(inh_o),
        .inhibit_limp_home_pin_oe(inh_oe));

    scr_host host (.sck(sck), .csn(csn), .mosi(mosi), .miso(miso));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Pulse counts and reset-out low length
    always @(posedge sys_clk) begin
        n_ev[0] += int'(wake_event === 1'b1);
        n_ev[1] += int'(cur_rst === 1'b1);
        n_ev[2] += int'(reen === 1'b1);
        n_ev[3] += int'(cur_irq === 1'b1);
        n_ev[4] += int'(cnt_fail === 1'b1);
        if (reset_out_n === 1'b0) begin
            lo_cnt++;
        end else if (lo_cnt != 0) begin
            lo_max = lo_cnt;
            lo_cnt = 0;
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task end_sim;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    function logic [11:0] rc();
        return 12'($random(seed)) & 12'h31f;
    endfunction : rc

    task fr(input logic [1:0] code, input logic readback_source_select, input logic ro,
            input logic [11:0] c, input int n);
        logic [15:0] e;
        e = readback_source_select ? {3'b100, gp[12:0]} : {4'h8, m_cfg};
        host.xfer({code, readback_source_select, ro, c}, n, rd);
        if (n == 16) begin
            chk(rd, e);
        end
        if (code == 2'b10 && !ro && n == 16) begin
            m_cfg = c;
        end
        cf_exp += int'(n != 16);
        cyc(6);
        chk({11'h0, gnd, aux, inh_oe, inh_o},
            {11'h0, m_cfg[9], m_cfg[7:6], m_cfg[1:0]});
        chk(16'(n_ev[4]), 16'(cf_exp));
    endtask : fr

    task stretch(input int len);
        @(posedge sys_clk) reset_ext_n <= 1'b0;
        @(posedge sys_clk) reset_ext_n <= 1'b1;
        cyc(30);
        chk(16'(lo_max >= len && lo_max <= len + 3), 16'h1);
    endtask : stretch

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        seed = 32'hec85;
        {n_fail, compares, cf_exp, lo_cnt, lo_max} = '0;
        n_ev = '{default: 0};
        m_cfg = 12'h000;
        {rstn, restart_entry, failsafe_entry, wake_tick} = 4'h0;
        {standby, wd_off, cur_rise, irq_en} = 4'h0;
        {reset_ext_n, wake_pin} = 2'b11;
        gp = 16'h0000;
        cyc(10);
        rstn <= 1'b1;
        cyc(3);
        for (int i = 0; i < 4; i++) begin
            fr(2'b10, 0, 0, rc() | 12'(i << 6), 16);
            fr(2'b10, 0, 1, rc(), 16);
            gp <= 16'($random(seed));
            cyc(1);
            fr(2'b10, 1, 1, rc(), 16);
            fr(2'b01, 0, 0, rc(), 16);
            fr(2'b10, 0, 0, rc(), 15 + 2 * (i % 2));
        end
        $display("test registers done");
        fr(2'b10, 0, 0, 12'h000, 16);
        stretch(LSHORT);
        for (int i = 0; i < 2; i++) begin
            fr(2'b10, 0, 0, 12'h000, 16);
            @(posedge sys_clk) {restart_entry, failsafe_entry} <= 2'(i + 1);
            @(posedge sys_clk) {restart_entry, failsafe_entry} <= 2'b00;
            m_cfg[8] = 1'b1;
            fr(2'b10, 0, 1, rc(), 16);
        end
        stretch(LLONG);
        $display("test reset length done");
        for (int i = 0; i < 4; i++) begin
            {standby, wd_off, irq_en} <= {1'b1, {2{i < 2}}};
            fr(2'b10, 0, 0, i[0] ? 12'h000 : 12'h010, 16);
            @(posedge sys_clk) cur_rise <= 1'b1;
            @(posedge sys_clk) cur_rise <= 1'b0;
            cyc(3);
        end
        chk(16'(n_ev[1] * 256 + n_ev[2] * 16 + n_ev[3]), 16'h121);
        $display("test current response done");
        fr(2'b10, 0, 0, 12'h00c, 16);
        wake_pin <= 1'b0;
        cyc(6);
        chk({14'h0, st_a, 1'(n_ev[0])}, 16'h2);
        @(posedge sys_clk) wake_tick <= 1'b1;
        @(posedge sys_clk) wake_tick <= 1'b0;
        cyc(4);
        chk({14'h0, st_a, 1'(n_ev[0])}, 16'h1);
        fr(2'b10, 0, 0, 12'h004, 16);
        wake_pin <= 1'b1;
        @(posedge sys_clk) wake_tick <= 1'b1;
        @(posedge sys_clk) wake_tick <= 1'b0;
        cyc(6);
        chk({13'h0, st_a, st_b, 1'(n_ev[0])}, 16'h3);
        fr(2'b10, 0, 0, 12'h008, 16);
        wake_pin <= 1'b0;
        cyc(6);
        chk({13'h0, st_a, st_b, 1'(n_ev[0] - 1)}, 16'h1);
        $display("test wake input done");
        end_sim();
    end

    initial begin
        #1000000;
        n_fail++;
        end_sim();
    end
endmodule : system_config_register_tb

`default_nettype wire
